// ===== hw/rwk_pkg.sv
package rwk_pkg;
	// ***************
	// Register map
	// ***************
	localparam logic [3:0] REG_CTRL_OFS = 4'h0;
	localparam logic [3:0] REG_KEY_OFS = 4'h4;
	localparam logic [3:0] REG_STAT_OFS = 4'h8;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] KEY_RESET = 16'h0000;
	localparam logic [15:0] CLEAR_KEY = 16'h5743;
	localparam int CTRL_LP_BIT = 15;
	localparam int PLL_SEL_LSB = 4;
	localparam int SEC_SEL_LSB = 2;
	localparam int FIRST_SEL_LSB = 0;
	localparam logic [15:0] CTRL_WMASK = 16'h803f;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ***************
	// Level codes
	// ***************
	typedef enum logic [1:0] {
		RWK_LVL_1V2 = 2'b00,
		RWK_LVL_1V0 = 2'b01,
		RWK_LVL_0V8 = 2'b11
	} rwk_level_t;

	typedef struct packed {
		logic low_power;
		rwk_level_t pll_level;
		rwk_level_t second_level;
		rwk_level_t first_level;
	} rwk_supply_t;
endpackage

// ===== hw/rwk_regs.sv
`timescale 1ns/1ps
module rwk_regs (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// AXI4-Lite read
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Regulator and watchdog side
	output rwk_pkg::rwk_supply_t supply,
	output logic wdt_clear
);
	// ***************
	// Write channel
	// ***************
	logic aw_held_reg, aw_held_next;
	logic w_held_reg, w_held_next;
	logic [3:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic [15:0] ctrl_reg, ctrl_next;
	logic clear_reg, clear_next;
	logic [15:0] key_seen_reg, key_seen_next;
	logic do_write;
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;

	function automatic logic [1:0] level_code(input logic [1:0] f);
		case (f)
			2'b10: level_code = 2'b01;
			2'b01: level_code = 2'b11;
			default: level_code = 2'b00;
		endcase
	endfunction

	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		ctrl_next = ctrl_reg;
		clear_next = 1'b0;
		key_seen_next = key_seen_reg;
		if (s_awvalid && !aw_held_reg && !bvalid_reg) begin
			aw_held_next = 1'b1;
			awaddr_next = s_awaddr;
		end
		if (s_wvalid && !w_held_reg && !bvalid_reg) begin
			w_held_next = 1'b1;
			wdata_next = s_wdata;
			wstrb_next = s_wstrb;
		end
		do_write = aw_held_reg && w_held_reg && !bvalid_reg;
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = rwk_pkg::RESP_OKAY;
			unique case (awaddr_reg)
				rwk_pkg::REG_CTRL_OFS: begin
					// Only bits 5:0 and bit 15 exist
					if (wstrb_reg[0])
						ctrl_next[7:0] = (wdata_reg[7:0]
							& rwk_pkg::CTRL_WMASK[7:0]);
					if (wstrb_reg[1])
						ctrl_next[15:8] = (wdata_reg[15:8]
							& rwk_pkg::CTRL_WMASK[15:8]);
				end
				rwk_pkg::REG_KEY_OFS: begin
					// Key acts only on a full halfword match
					if (wstrb_reg[1:0] == 2'b11) begin
						key_seen_next = wdata_reg[15:0];
						clear_next = (wdata_reg[15:0]
							== rwk_pkg::CLEAR_KEY);
					end
				end
				rwk_pkg::REG_STAT_OFS: ;
				default: bresp_next = rwk_pkg::RESP_SLVERR;
			endcase
		end
		if (bvalid_reg && s_bready)
			bvalid_next = 1'b0;
		// Readies registered from the next hold state, same timing
		awready_next = !aw_held_next && !bvalid_next;
		wready_next = !w_held_next && !bvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= rwk_pkg::RESP_OKAY;
			ctrl_reg <= rwk_pkg::CTRL_RESET;
			clear_reg <= 1'b0;
			key_seen_reg <= rwk_pkg::KEY_RESET;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			ctrl_reg <= ctrl_next;
			clear_reg <= clear_next;
			key_seen_reg <= key_seen_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
		end
	end

	assign s_awready = awready_reg;
	assign s_wready = wready_reg;
	assign s_bvalid = bvalid_reg;
	assign s_bresp = bresp_reg;
	assign wdt_clear = clear_reg;

	// ***************
	// Supply decode
	// ***************
	// Outputs come from a register of decoded codes
	rwk_pkg::rwk_supply_t supply_reg, supply_next;

	always_comb begin
		supply_next.low_power = ctrl_reg[rwk_pkg::CTRL_LP_BIT];
		supply_next.pll_level = rwk_pkg::rwk_level_t'(level_code(
			ctrl_reg[rwk_pkg::PLL_SEL_LSB +: 2]));
		supply_next.second_level = rwk_pkg::rwk_level_t'(level_code(
			ctrl_reg[rwk_pkg::SEC_SEL_LSB +: 2]));
		supply_next.first_level = rwk_pkg::rwk_level_t'(level_code(
			ctrl_reg[rwk_pkg::FIRST_SEL_LSB +: 2]));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			supply_reg <= '0;
		else
			supply_reg <= supply_next;
	end
	assign supply = supply_reg;

	// ***************
	// Read channel
	// ***************
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic arready_reg, arready_next;

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rresp_next = rwk_pkg::RESP_OKAY;
			unique case (s_araddr)
				rwk_pkg::REG_CTRL_OFS:
					rdata_next = {16'h0000, ctrl_reg};
				// Write-only key reads as zero
				rwk_pkg::REG_KEY_OFS: rdata_next = 32'h0000_0000;
				// Last key written, for software diagnosis
				rwk_pkg::REG_STAT_OFS:
					rdata_next = {16'h0000, key_seen_reg};
				default: begin
					rdata_next = 32'h0000_0000;
					rresp_next = rwk_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_rready) begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= rwk_pkg::RESP_OKAY;
			arready_reg <= 1'b1;
		end else begin
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			arready_reg <= arready_next;
		end
	end

	assign s_arready = arready_reg;
	assign s_rvalid = rvalid_reg;
	assign s_rdata = rdata_reg;
	assign s_rresp = rresp_reg;

	// ***************
	// Checks
	// ***************
	chk_ctrl_unimpl: assert property (
		@(posedge aclk) disable iff (!aresetn)
		ctrl_reg[14:6] == 9'h000) else $error("unimplemented bits set");
	chk_key_clear: assert property (
		@(posedge aclk) disable iff (!aresetn)
		do_write && awaddr_reg == rwk_pkg::REG_KEY_OFS
		&& wstrb_reg[1:0] == 2'b11 && wdata_reg[15:0] == 16'h5743
		|=> wdt_clear ##1 !wdt_clear) else $error("key missed");
	chk_key_reject: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wdt_clear |-> $past(awaddr_reg) == rwk_pkg::REG_KEY_OFS
		&& $past(wstrb_reg[1:0]) == 2'b11
		&& $past(wdata_reg[15:0]) == 16'h5743)
		else $error("bad clear");
	chk_pll_decode: assert property (
		@(posedge aclk) disable iff (!aresetn)
		ctrl_reg[5:4] == 2'b01
		|=> supply.pll_level == rwk_pkg::RWK_LVL_0V8)
		else $error("pll decode");
	chk_sec_decode: assert property (
		@(posedge aclk) disable iff (!aresetn)
		ctrl_reg[3:2] == 2'b10
		|=> supply.second_level == rwk_pkg::RWK_LVL_1V0)
		else $error("second decode");
	chk_first_decode: assert property (
		@(posedge aclk) disable iff (!aresetn)
		ctrl_reg[1:0] == 2'b11
		|=> supply.first_level == rwk_pkg::RWK_LVL_1V2)
		else $error("first decode");
	chk_key_read: assert property (
		@(posedge aclk) disable iff (!aresetn)
		s_arvalid && s_arready && s_araddr == rwk_pkg::REG_KEY_OFS
		|=> s_rvalid && s_rdata == 32'h0) else $error("key readable");
	chk_lp_follow: assert property (
		@(posedge aclk) disable iff (!aresetn)
		ctrl_reg[15] |=> supply.low_power) else $error("low power lost");
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic aclk = 0, aresetn = 0;
	logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata, d, x;
	logic awready, wready, bvalid, arready, rvalid, wdt_clear;
	logic [1:0] bresp, rresp, r;
	rwk_pkg::rwk_supply_t supply;
	logic [31:0] cs [3] = '{32'hffffffff, 32'h00007ff9, 32'h00008006};
	logic [35:0] ks [5] = '{36'h0_5743_f, 36'h0_5743_3, 36'h0_1234_1,
		36'h0_0000_f, 36'h0_5742_f};
	logic kx [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
	logic [15:0] ksn = 16'h0000;
	int n_errors = 0, n_tests = 0, n_clr = 0, c;
	always #25 aclk = ~aclk;
	always @(posedge aclk) if (wdt_clear === 1'b1) n_clr++;
	rwk_regs i_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
		.s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
		.s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
		.s_rready(rready), .supply(supply), .wdt_clear(wdt_clear));
	// ***************
	// Bus tasks
	// ***************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
		int k;
		@(posedge aclk);
		awaddr <= a; wdata <= v; wstrb <= s;
		awvalid <= 1; wvalid <= 1; bready <= 1;
		for (k = 0; k < 60; k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid === 1'b1) break;
		end
		if (k == 60) n_errors++;
		r = bresp;
		bready <= 0;
	endtask
	task rd(input logic [3:0] a);
		int k;
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		for (k = 0; k < 60; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid === 1'b1) break;
		end
		if (k == 60) n_errors++;
		x = rdata; r = rresp;
		rready <= 0;
	endtask
	// Register code 10 is 1.0V, 01 is 0.8V, both 00 and 11 are 1.2V
	function automatic logic [1:0] lvl(input logic [1:0] cd);
		case (cd)
			2'b10: lvl = rwk_pkg::RWK_LVL_1V0;
			2'b01: lvl = rwk_pkg::RWK_LVL_0V8;
			default: lvl = rwk_pkg::RWK_LVL_1V2;
		endcase
	endfunction
	task give_verdict;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#2000000;
		n_errors++;
		give_verdict;
	end
	initial begin
		d = $urandom(32'hd86d);
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rd(rwk_pkg::REG_CTRL_OFS);
		chk(x, 32'h0);
		chk(32'(supply), 32'h0);
		for (int i = 0; i < 12; i++) begin
			d = (i < 3) ? cs[i] : $urandom;
			wr(rwk_pkg::REG_CTRL_OFS, d, 4'hf);
			chk(32'(r), 32'(rwk_pkg::RESP_OKAY));
			repeat (2) @(posedge aclk);
			#1 chk(32'(supply), 32'({d[15], lvl(d[5:4]), lvl(d[3:2]),
				lvl(d[1:0])}));
			rd(rwk_pkg::REG_CTRL_OFS);
			chk(x, d & 32'h0000803f);
		end
		for (int i = 0; i < 5; i++) begin
			c = n_clr;
			wr(rwk_pkg::REG_KEY_OFS, ks[i][35:4], ks[i][3:0]);
			chk(32'(r), 32'(rwk_pkg::RESP_OKAY));
			@(posedge aclk);
			#1 chk(32'(n_clr - c), 32'(kx[i]));
			// Only full low-halfword writes reach the key
			if (ks[i][1:0] == 2'b11)
				ksn = ks[i][19:4];
			rd(rwk_pkg::REG_STAT_OFS);
			chk(x, {16'h0000, ksn});
		end
		rd(rwk_pkg::REG_KEY_OFS);
		chk(x, 32'h0);
		rd(4'hc);
		chk(32'(r), 32'(rwk_pkg::RESP_SLVERR));
		c = n_clr;
		wr(4'hc, 32'h00005743, 4'hf);
		chk(32'(r), 32'(rwk_pkg::RESP_SLVERR));
		repeat (2) @(posedge aclk);
		#1 chk(32'(n_clr - c), 32'h0);
		// Sleep preparation: low-power bit and reduced levels
		wr(rwk_pkg::REG_CTRL_OFS, 32'h00008026, 4'h3);
		repeat (2) @(posedge aclk);
		#1 chk(32'(supply), 32'({1'b1, rwk_pkg::RWK_LVL_1V0,
			rwk_pkg::RWK_LVL_0V8, rwk_pkg::RWK_LVL_1V0}));
		// Upper lane only: bit 15 cleared, low byte kept
		wr(rwk_pkg::REG_CTRL_OFS, 32'h000000ff, 4'h2);
		rd(rwk_pkg::REG_CTRL_OFS);
		chk(x, 32'h00000026);
		// Mid-run reset returns CTRL, STAT and the supply outputs to zero
		@(posedge aclk);
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rd(rwk_pkg::REG_CTRL_OFS);
		chk(x, 32'h0);
		chk(32'(supply), 32'h0);
		rd(rwk_pkg::REG_STAT_OFS);
		chk(x, 32'h0);
		give_verdict;
	end
endmodule
